// *** laot_cfg.svh ***
/*
 * Constants for the lane alarm and offset trim register slice: offsets, field
 * positions, reset values.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef LAOT_CFG_SVH
`define LAOT_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses of the control space)
`define LAOT_LANE_ALARM_ADDR 12'h2C4
`define LAOT_CORE0_TRIM_ADDR 12'h330
`define LAOT_CORE1_TRIM_ADDR 12'h332
`define LAOT_CORE2A_TRIM_ADDR 12'h334
`define LAOT_CORE2B_TRIM_ADDR 12'h336
`define LAOT_IRQ_STATUS_ADDR 12'h3F0
`define LAOT_IRQ_MASK_ADDR 12'h3F2
`define LAOT_CAL_CTRL_ADDR 12'h3F4
`define LAOT_CAL_STATUS_ADDR 12'h3F6

// ==========================================================================
// Field layouts and reset values
`define LAOT_NUM_LANES 8
`define LAOT_TRIM_MSB 11
`define LAOT_TRIM_W 12
`define LAOT_LANE_ALARM_RESET 8'hFF
`define LAOT_TRIM_RESET 12'h000
`define LAOT_IRQ_MASK_RESET 4'h0
`define LAOT_CAL_FG_OS_BIT 0
`define LAOT_BACKGROUND_CALIBRATION_ENABLE_BIT 1
`define LAOT_CONTINUOUS_OFFSET_TRACKING_ENABLE_BIT 2
`define LAOT_IRQ_LANE_BIT 0
`define LAOT_IRQ_FUSE_BIT 1
`define LAOT_IRQ_ACCESS_BIT 2
`define LAOT_IRQ_DONE_BIT 3

`endif

// *** laot_lane_alarm.sv ***
/*
 * Eight sticky per-lane FIFO alarm bits with write-one-to-clear and a clear-all.
 * Assumes fault inputs are synchronous to ref_clk and clears are one-cycle pulses.
 */
`timescale 1ns/10ps
`include "laot_cfg.svh"

module laot_lane_alarm (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [`LAOT_NUM_LANES-1:0] lane_fault,
	input wire logic [`LAOT_NUM_LANES-1:0] clear_bits,
	input wire logic clear_all,
	output logic [`LAOT_NUM_LANES-1:0] alarm_q
);

	// ==========================================================================
	// Per-lane sticky bits
	genvar i;
	generate
		for (i = 0; i < `LAOT_NUM_LANES; i = i + 1) begin : g_lane
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					alarm_q[i] <= 1'b1;
				end else if (lane_fault[i]) begin
					// A fault in the clear cycle wins, so a lingering fault re-trips at once.
					alarm_q[i] <= 1'b1;
				end else if (clear_bits[i] || clear_all) begin
					alarm_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	a_fault_sets_bit: assert property (@(posedge ref_clk) disable iff (reset)
		(|lane_fault) |=> ((alarm_q & $past(lane_fault)) == $past(lane_fault)))
		else $error("lane fault did not set its alarm bit");

	a_clear_all_works: assert property (@(posedge ref_clk) disable iff (reset)
		(clear_all && lane_fault == '0) |=> alarm_q == '0)
		else $error("summary clear left a lane alarm set");

endmodule : laot_lane_alarm

// *** laot_pkg.sv ***
/*
 * Types shared by the lane alarm and offset trim register slice.
 * Assumes laot_cfg.svh supplies the widths.
 */
`include "laot_cfg.svh"

package laot_pkg;

	typedef logic [`LAOT_TRIM_MSB:0] laot_trim_t;
	typedef logic [`LAOT_NUM_LANES-1:0] laot_lanes_t;

	// Who may touch the trim registers, from the calibration settings.
	typedef enum logic [1:0] {
		LAOT_ACC_FREE = 2'b00,
		LAOT_ACC_WAIT_DONE = 2'b01,
		LAOT_ACC_FORBIDDEN = 2'b10,
		LAOT_ACC_BUSY = 2'b11
	} laot_access_e;

endpackage : laot_pkg

// *** laot_regs.sv ***
/*
 * Register slice: per-lane FIFO alarm register, four offset trim registers,
 * interrupt status and mask, calibration settings mirror.
 * Assumes a plain register port on ref_clk, lane faults and calibration state
 * arriving from other clock domains, and a fuse loader that pulses fuse_load_valid.
 */
// How it works
// - Each of eight lanes has an alarm bit set whenever its FIFO overflows or underflows.
// - After reset every lane alarm bit reads as one.
// - Writing one to a lane alarm bit clears it and writing zero leaves it alone.
// - A fault still present when its bit is cleared sets the bit again at once.
// - Writing one to the summary FIFO alarm bit clears all lane alarm bits; here a pulse on the fifo_alarm_summary_clear input does it, not a register bit.
// - The core 0 trim holds a 12-bit unsigned value applied as core 0 offset.
// - The core 1 trim holds a 12-bit value applied as core 1 offset.
// - Core 2 uses its own 12-bit trim register while sampling input A.
// - Core 2 uses a separate 12-bit trim register while sampling input B.
// - Trim defaults are loaded from fuse memory rather than fixed constants; here reset loads 12'h000 until fuse_load_valid pulses.
// - Foreground offset with background but no tracking still trims the spare cores.
`timescale 1ns/10ps
`include "laot_cfg.svh"

module laot_regs (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [11:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic [`LAOT_NUM_LANES-1:0] lane_fifo_fault,
	input wire logic fifo_alarm_summary_clear,
	input wire logic offset_cal_busy,
	input wire logic foreground_calibration_complete,
	input wire logic fuse_load_valid,
	input wire logic [`LAOT_TRIM_MSB:0] fuse_core0_trim,
	input wire logic [`LAOT_TRIM_MSB:0] fuse_core1_trim,
	input wire logic [`LAOT_TRIM_MSB:0] fuse_core2a_trim,
	input wire logic [`LAOT_TRIM_MSB:0] fuse_core2b_trim,
	input wire logic core2_select_input_b,
	output logic [`LAOT_TRIM_MSB:0] core0_offset_trim,
	output logic [`LAOT_TRIM_MSB:0] core1_offset_trim,
	output logic [`LAOT_TRIM_MSB:0] core2_offset_trim,
	output logic foreground_offset_calibration_enable,
	output logic background_calibration_enable,
	output logic continuous_offset_tracking_enable,
	output logic spare_core_offset_cal,
	output logic [`LAOT_NUM_LANES-1:0] lane_fifo_alarm_bits,
	output logic irq
);

	// ==========================================================================
	// Input synchronisers
	logic [`LAOT_NUM_LANES-1:0] fault_meta_q;
	logic [`LAOT_NUM_LANES-1:0] fault_sync_q;
	logic busy_meta_q;
	logic busy_sync_q;
	logic done_meta_q;
	logic done_sync_q;
	logic done_prev_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fault_meta_q <= '0;
			fault_sync_q <= '0;
			busy_meta_q <= 1'b0;
			busy_sync_q <= 1'b0;
			done_meta_q <= 1'b0;
			done_sync_q <= 1'b0;
			done_prev_q <= 1'b0;
		end else begin
			fault_meta_q <= lane_fifo_fault;
			fault_sync_q <= fault_meta_q;
			busy_meta_q <= offset_cal_busy;
			busy_sync_q <= busy_meta_q;
			done_meta_q <= foreground_calibration_complete;
			done_sync_q <= done_meta_q;
			done_prev_q <= done_sync_q;
		end
	end

	// ==========================================================================
	// Address decode
	logic hit_lane;
	logic hit_t0;
	logic hit_t1;
	logic hit_t2a;
	logic hit_t2b;
	logic hit_irq_status;
	logic hit_irq_mask;
	logic hit_cal_ctrl;
	logic hit_cal_status;
	logic hit_trim;

	assign hit_lane = reg_addr == `LAOT_LANE_ALARM_ADDR;
	assign hit_t0 = reg_addr == `LAOT_CORE0_TRIM_ADDR;
	assign hit_t1 = reg_addr == `LAOT_CORE1_TRIM_ADDR;
	assign hit_t2a = reg_addr == `LAOT_CORE2A_TRIM_ADDR;
	assign hit_t2b = reg_addr == `LAOT_CORE2B_TRIM_ADDR;
	assign hit_irq_status = reg_addr == `LAOT_IRQ_STATUS_ADDR;
	assign hit_irq_mask = reg_addr == `LAOT_IRQ_MASK_ADDR;
	assign hit_cal_ctrl = reg_addr == `LAOT_CAL_CTRL_ADDR;
	assign hit_cal_status = reg_addr == `LAOT_CAL_STATUS_ADDR;
	assign hit_trim = hit_t0 || hit_t1 || hit_t2a || hit_t2b;

	// ==========================================================================
	// Calibration settings and trim access policy
	logic [2:0] cal_ctrl_q;
	laot_pkg::laot_access_e access_mode;
	logic trim_access_ok;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cal_ctrl_q <= 3'h0;
		end else if (reg_write && hit_cal_ctrl) begin
			cal_ctrl_q <= reg_wdata[2:0];
		end
	end

	assign foreground_offset_calibration_enable = cal_ctrl_q[`LAOT_CAL_FG_OS_BIT];
	assign background_calibration_enable = cal_ctrl_q[`LAOT_BACKGROUND_CALIBRATION_ENABLE_BIT];
	assign continuous_offset_tracking_enable = cal_ctrl_q[`LAOT_CONTINUOUS_OFFSET_TRACKING_ENABLE_BIT];
	// Spare cores still get their offset during the foreground step.
	assign spare_core_offset_cal = cal_ctrl_q[`LAOT_CAL_FG_OS_BIT] &&
		cal_ctrl_q[`LAOT_BACKGROUND_CALIBRATION_ENABLE_BIT] && !cal_ctrl_q[`LAOT_CONTINUOUS_OFFSET_TRACKING_ENABLE_BIT];

	always_comb begin
		if (busy_sync_q) begin
			access_mode = laot_pkg::LAOT_ACC_BUSY;
		end else if (background_calibration_enable && continuous_offset_tracking_enable) begin
			access_mode = laot_pkg::LAOT_ACC_FORBIDDEN;
		end else if (foreground_offset_calibration_enable) begin
			access_mode = laot_pkg::LAOT_ACC_WAIT_DONE;
		end else begin
			access_mode = laot_pkg::LAOT_ACC_FREE;
		end
	end

	// The device protects itself: trim writes outside the allowed window are dropped
	// and flagged, since a half-calibrated trim would corrupt the converter.
	always_comb begin
		unique case (access_mode)
			laot_pkg::LAOT_ACC_FREE: trim_access_ok = 1'b1;
			laot_pkg::LAOT_ACC_WAIT_DONE: trim_access_ok = done_sync_q;
			laot_pkg::LAOT_ACC_FORBIDDEN: trim_access_ok = 1'b0;
			laot_pkg::LAOT_ACC_BUSY: trim_access_ok = 1'b0;
		endcase
	end

	logic trim_wr;
	logic bad_access;
	assign trim_wr = reg_write && hit_trim && trim_access_ok;
	assign bad_access = (reg_write || reg_read) && hit_trim && !trim_access_ok;

	// ==========================================================================
	// Offset trim registers
	logic [`LAOT_TRIM_MSB:0] trim0_q;
	logic [`LAOT_TRIM_MSB:0] trim1_q;
	logic [`LAOT_TRIM_MSB:0] trim2a_q;
	logic [`LAOT_TRIM_MSB:0] trim2b_q;
	logic fuse_done_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			trim0_q <= `LAOT_TRIM_RESET;
			trim1_q <= `LAOT_TRIM_RESET;
			trim2a_q <= `LAOT_TRIM_RESET;
			trim2b_q <= `LAOT_TRIM_RESET;
		end else if (fuse_load_valid) begin
			trim0_q <= fuse_core0_trim;
			trim1_q <= fuse_core1_trim;
			trim2a_q <= fuse_core2a_trim;
			trim2b_q <= fuse_core2b_trim;
		end else if (trim_wr) begin
			// Bits 15:12 are reserved; software keeps them zero and they are not stored.
			if (hit_t0) begin
				trim0_q <= reg_wdata[`LAOT_TRIM_MSB:0];
			end
			if (hit_t1) begin
				trim1_q <= reg_wdata[`LAOT_TRIM_MSB:0];
			end
			if (hit_t2a) begin
				trim2a_q <= reg_wdata[`LAOT_TRIM_MSB:0];
			end
			if (hit_t2b) begin
				trim2b_q <= reg_wdata[`LAOT_TRIM_MSB:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fuse_done_q <= 1'b0;
		end else if (fuse_load_valid) begin
			fuse_done_q <= 1'b1;
		end
	end

	assign core0_offset_trim = trim0_q;
	assign core1_offset_trim = trim1_q;
	// Core 2 switches trims with its input so each input keeps its own correction.
	assign core2_offset_trim = core2_select_input_b ? trim2b_q : trim2a_q;

	// ==========================================================================
	// Lane FIFO alarm bits
	logic [`LAOT_NUM_LANES-1:0] lane_clear;
	assign lane_clear = (reg_write && hit_lane) ? reg_wdata[`LAOT_NUM_LANES-1:0] : '0;

	laot_lane_alarm u_lane_alarm (
		.ref_clk(ref_clk),
		.reset(reset),
		.lane_fault(fault_sync_q),
		.clear_bits(lane_clear),
		.clear_all(fifo_alarm_summary_clear),
		.alarm_q(lane_fifo_alarm_bits)
	);

	// ==========================================================================
	// Interrupt status and mask
	logic [3:0] irq_status_q;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_event;
	logic status_rd;

	assign irq_event[`LAOT_IRQ_LANE_BIT] = |fault_sync_q;
	assign irq_event[`LAOT_IRQ_FUSE_BIT] = fuse_load_valid;
	assign irq_event[`LAOT_IRQ_ACCESS_BIT] = bad_access;
	assign irq_event[`LAOT_IRQ_DONE_BIT] = done_sync_q && !done_prev_q;
	assign status_rd = reg_read && hit_irq_status;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_status_q <= 4'h0;
		end else begin
			// A new event in the reading cycle survives the clear-on-read.
			irq_status_q <= (status_rd ? 4'h0 : irq_status_q) | irq_event;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_mask_q <= `LAOT_IRQ_MASK_RESET;
		end else if (reg_write && hit_irq_mask) begin
			irq_mask_q <= reg_wdata[3:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// ==========================================================================
	// Read data, one cycle after the read strobe; unmapped addresses read zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read) begin
			if (hit_lane) begin
				reg_rdata <= {8'h00, lane_fifo_alarm_bits};
			end else if (hit_trim && !trim_access_ok) begin
				reg_rdata <= 16'h0000;
			end else if (hit_t0) begin
				reg_rdata <= {4'h0, trim0_q};
			end else if (hit_t1) begin
				reg_rdata <= {4'h0, trim1_q};
			end else if (hit_t2a) begin
				reg_rdata <= {4'h0, trim2a_q};
			end else if (hit_t2b) begin
				reg_rdata <= {4'h0, trim2b_q};
			end else if (hit_irq_status) begin
				reg_rdata <= {12'h000, irq_status_q};
			end else if (hit_irq_mask) begin
				reg_rdata <= {12'h000, irq_mask_q};
			end else if (hit_cal_ctrl) begin
				reg_rdata <= {13'h0000, cal_ctrl_q};
			end else if (hit_cal_status) begin
				reg_rdata <= {12'h000, fuse_done_q, done_sync_q, busy_sync_q, trim_access_ok};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ==========================================================================
	// Checks
	a_lane_reset_ones: assert property (@(posedge ref_clk)
		$fell(reset) |-> lane_fifo_alarm_bits == 8'hFF)
		else $error("lane alarms not all set after reset");

	a_lane_w1c: assert property (@(posedge ref_clk) disable iff (reset)
		(reg_write && hit_lane && fault_sync_q == '0 && !fifo_alarm_summary_clear)
		|=> ((lane_fifo_alarm_bits & $past(reg_wdata[7:0])) == 8'h00) &&
		((lane_fifo_alarm_bits & ~$past(reg_wdata[7:0])) ==
		($past(lane_fifo_alarm_bits) & ~$past(reg_wdata[7:0]))))
		else $error("lane alarm write-one-clear wrong");

	a_fault_persists: assert property (@(posedge ref_clk) disable iff (reset)
		(|lane_fifo_fault) |-> ##3 ((lane_fifo_alarm_bits & $past(lane_fifo_fault, 3))
		== $past(lane_fifo_fault, 3)))
		else $error("persisting lane fault not flagged");

	a_trim0_write: assert property (@(posedge ref_clk) disable iff (reset)
		(trim_wr && hit_t0 && !fuse_load_valid) |=> core0_offset_trim == $past(reg_wdata[11:0]))
		else $error("core 0 trim not applied");

	a_trim1_write: assert property (@(posedge ref_clk) disable iff (reset)
		(trim_wr && hit_t1 && !fuse_load_valid) |=> core1_offset_trim == $past(reg_wdata[11:0]))
		else $error("core 1 trim not applied");

	a_core2_input_a: assert property (@(posedge ref_clk) disable iff (reset)
		(trim_wr && hit_t2a && !fuse_load_valid) ##1 !core2_select_input_b
		|-> core2_offset_trim == $past(reg_wdata[11:0]))
		else $error("core 2 input A trim not applied");

	a_core2_input_b: assert property (@(posedge ref_clk) disable iff (reset)
		(trim_wr && hit_t2b && !fuse_load_valid) ##1 core2_select_input_b
		|-> core2_offset_trim == $past(reg_wdata[11:0]))
		else $error("core 2 input B trim not applied");

	a_fuse_load: assert property (@(posedge ref_clk) disable iff (reset)
		fuse_load_valid |=> core0_offset_trim == $past(fuse_core0_trim) &&
		trim2b_q == $past(fuse_core2b_trim))
		else $error("fuse defaults not loaded");

	// A refused write must leave the core 0 and core 1 trims alone, whatever the reason for refusal.
	a_trim_refused: assert property (@(posedge ref_clk) disable iff (reset)
		(reg_write && hit_trim && !trim_access_ok && !fuse_load_valid)
		|=> core0_offset_trim == $past(core0_offset_trim) &&
		core1_offset_trim == $past(core1_offset_trim))
		else $error("refused trim write changed a trim");

	a_tracking_blocks: assert property (@(posedge ref_clk) disable iff (reset)
		(background_calibration_enable && continuous_offset_tracking_enable &&
		reg_write && hit_t0 && !fuse_load_valid)
		|=> core0_offset_trim == $past(core0_offset_trim))
		else $error("trim written while tracking enabled");

	a_spare_cal: assert property (@(posedge ref_clk) disable iff (reset)
		spare_core_offset_cal |-> foreground_offset_calibration_enable &&
		!continuous_offset_tracking_enable)
		else $error("spare core calibration in wrong setting");

endmodule : laot_regs

// *** laot_regs_tb_top.sv ***
/*
 * Self-checking testbench for the lane alarm and offset trim register slice.
 * Assumes laot_regs on a 40 MHz ref_clk with a synchronous active-high reset and
 * a plain register port whose read data stands in the cycle after the read strobe.
 */
`timescale 1ns/10ps
`include "laot_cfg.svh"

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("Error %s expected %0h seen %0h", nm, (exp), (got)); end end

module laot_regs_tb_top;
	logic ref_clk;
	logic reset;
	logic [11:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [15:0] reg_rdata;
	logic [7:0] lane_fifo_fault;
	logic fifo_alarm_summary_clear;
	logic offset_cal_busy;
	logic foreground_calibration_complete;
	logic fuse_load_valid;
	logic [11:0] fuse_trim [4];
	logic core2_select_input_b;
	logic [11:0] core0_offset_trim;
	logic [11:0] core1_offset_trim;
	logic [11:0] core2_offset_trim;
	logic fg_en;
	logic bg_en;
	logic trk_en;
	logic spare_core_offset_cal;
	logic [7:0] lane_fifo_alarm_bits;
	logic irq;
	int err_total;
	int n_checks;
	int m_alarm;
	int m_trim [4];
	int ok;
	int st_exp;
	int c_ctrl [9] = '{0, 2, 1, 1, 3, 3, 6, 7, 0};
	int c_busy [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
	int c_done [9] = '{0, 0, 0, 1, 0, 1, 1, 1, 0};
	logic [31:0] rnd;
	logic [15:0] rdat;

	laot_regs i_laot_regs (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.lane_fifo_fault(lane_fifo_fault), .fifo_alarm_summary_clear(fifo_alarm_summary_clear),
		.offset_cal_busy(offset_cal_busy),
		.foreground_calibration_complete(foreground_calibration_complete),
		.fuse_load_valid(fuse_load_valid), .fuse_core0_trim(fuse_trim[0]),
		.fuse_core1_trim(fuse_trim[1]), .fuse_core2a_trim(fuse_trim[2]),
		.fuse_core2b_trim(fuse_trim[3]), .core2_select_input_b(core2_select_input_b),
		.core0_offset_trim(core0_offset_trim), .core1_offset_trim(core1_offset_trim),
		.core2_offset_trim(core2_offset_trim), .foreground_offset_calibration_enable(fg_en),
		.background_calibration_enable(bg_en), .continuous_offset_tracking_enable(trk_en),
		.spare_core_offset_cal(spare_core_offset_cal),
		.lane_fifo_alarm_bits(lane_fifo_alarm_bits), .irq(irq)
	);

	// ==========================================================================
	// Bus and helper tasks
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// Each access waits for a fresh edge, so a strobe is never assigned twice in one step.
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		rdat = reg_rdata;
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic chk_trims;
		`CHK("core0_trim", m_trim[0], core0_offset_trim)
		`CHK("core1_trim", m_trim[1], core1_offset_trim)
		if (core2_select_input_b) begin
			`CHK("core2_trim_b", m_trim[3], core2_offset_trim)
		end else begin
			`CHK("core2_trim_a", m_trim[2], core2_offset_trim)
		end
	endtask : chk_trims

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask : end_test

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test

	// ==========================================================================
	// Clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		stop_test();
	end

	// ==========================================================================
	// Main sequence
	initial begin
		reset = 1'b1;
		reg_addr = 12'h000;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		lane_fifo_fault = 8'h00;
		fifo_alarm_summary_clear = 1'b0;
		offset_cal_busy = 1'b0;
		foreground_calibration_complete = 1'b0;
		fuse_load_valid = 1'b0;
		fuse_trim = '{12'h000, 12'h000, 12'h000, 12'h000};
		core2_select_input_b = 1'b0;
		err_total = 0;
		n_checks = 0;
		rnd = 32'h05C8;
		m_trim = '{0, 0, 0, 0};
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		rd(`LAOT_LANE_ALARM_ADDR);
		`CHK("alarm_reset", 16'h00FF, rdat)
		m_alarm = 255;
		for (int i = 0; i < 4; i++) begin
			rd(`LAOT_CORE0_TRIM_ADDR + 12'(2 * i));
			`CHK("trim_reset", 0, rdat)
		end
		rd(`LAOT_IRQ_MASK_ADDR);
		`CHK("mask_reset", 0, rdat)
		rd(12'h100);
		`CHK("unmapped_read", 0, rdat)
		end_test("reset");
		// Four random write-one patterns, then all ones; zero bits must leave their alarm untouched.
		for (int k = 0; k < 5; k++) begin
			rnd = lfsr_next(rnd);
			wr(`LAOT_LANE_ALARM_ADDR, (k == 4) ? 16'h00FF : {8'h00, rnd[7:0]});
			m_alarm = m_alarm & ~((k == 4) ? 255 : int'(rnd[7:0])) & 255;
			`CHK("alarm_w1c", m_alarm, lane_fifo_alarm_bits)
			rd(`LAOT_LANE_ALARM_ADDR);
			`CHK("alarm_read", m_alarm, rdat)
		end
		end_test("w1c");
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			lane_fifo_fault <= 8'(1 << i);
			tick(4);
			m_alarm = m_alarm | (1 << i);
			`CHK("alarm_set", m_alarm, lane_fifo_alarm_bits)
			wr(`LAOT_LANE_ALARM_ADDR, 16'(1 << i));
			`CHK("alarm_retrip", m_alarm, lane_fifo_alarm_bits)
		end
		@(posedge ref_clk);
		lane_fifo_fault <= 8'h00;
		tick(4);
		@(posedge ref_clk);
		fifo_alarm_summary_clear <= 1'b1;
		@(posedge ref_clk);
		fifo_alarm_summary_clear <= 1'b0;
		#1;
		m_alarm = 0;
		`CHK("alarm_clear_all", m_alarm, lane_fifo_alarm_bits)
		end_test("lane_faults");
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr_next(rnd);
			// Input B is selected while its trim is written, so the new value goes live at once.
			@(posedge ref_clk);
			core2_select_input_b <= (i == 3);
			wr(`LAOT_CORE0_TRIM_ADDR + 12'(2 * i), {4'h0, rnd[11:0]});
			m_trim[i] = int'(rnd[11:0]);
			rd(`LAOT_CORE0_TRIM_ADDR + 12'(2 * i));
			`CHK("trim_read", m_trim[i], rdat)
		end
		for (int s = 0; s < 2; s++) begin
			@(posedge ref_clk);
			core2_select_input_b <= s[0];
			tick(1);
			chk_trims();
		end
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr_next(rnd);
			fuse_trim[i] <= rnd[11:0];
			m_trim[i] = int'(rnd[11:0]);
		end
		@(posedge ref_clk);
		fuse_load_valid <= 1'b1;
		@(posedge ref_clk);
		fuse_load_valid <= 1'b0;
		tick(1);
		chk_trims();
		rd(`LAOT_CORE2B_TRIM_ADDR);
		`CHK("fuse_read", m_trim[3], rdat)
		end_test("trims");
		// Each row is one calibration setting; the device must drop refused accesses.
		for (int k = 0; k < 9; k++) begin
			wr(`LAOT_CAL_CTRL_ADDR, 16'(c_ctrl[k]));
			@(posedge ref_clk);
			offset_cal_busy <= c_busy[k][0];
			foreground_calibration_complete <= c_done[k][0];
			tick(4);
			ok = !c_busy[k] && ((c_ctrl[k] & 6) != 6) && !((c_ctrl[k] & 1) && !c_done[k]);
			`CHK("spare_cal", ((c_ctrl[k] & 7) == 3), spare_core_offset_cal)
			`CHK("fg_enable", c_ctrl[k] & 1, fg_en)
			`CHK("bg_enable", (c_ctrl[k] >> 1) & 1, bg_en)
			`CHK("trk_enable", (c_ctrl[k] >> 2) & 1, trk_en)
			rd(`LAOT_IRQ_STATUS_ADDR);
			// Lane and fuse events are still pending on the first row; done flags its rising edge.
			st_exp = (k == 0) ? 3 : 0;
			if (c_done[k] != 0 && (k == 0 || c_done[k - 1] == 0)) st_exp = st_exp | 8;
			`CHK("status_events", st_exp, rdat)
			rd(`LAOT_CAL_STATUS_ADDR);
			`CHK("cal_status", 8 | (c_done[k] << 2) | (c_busy[k] << 1) | ok, rdat)
			rd(`LAOT_CAL_CTRL_ADDR);
			`CHK("cal_ctrl_read", c_ctrl[k], rdat)
			rnd = lfsr_next(rnd);
			wr(`LAOT_CORE0_TRIM_ADDR, {4'h0, rnd[11:0]});
			if (ok != 0) m_trim[0] = int'(rnd[11:0]);
			`CHK("trim_gate_write", m_trim[0], core0_offset_trim)
			rd(`LAOT_CORE0_TRIM_ADDR);
			`CHK("trim_gate_read", (ok != 0) ? m_trim[0] : 0, rdat)
			`CHK("irq_masked", 0, irq)
			wr(`LAOT_IRQ_MASK_ADDR, 16'h0004);
			`CHK("irq_refused", (ok == 0), irq)
			rd(`LAOT_IRQ_STATUS_ADDR);
			`CHK("status_refused", (ok == 0) ? 4 : 0, rdat & 16'h0004)
			`CHK("irq_cleared", 0, irq)
			wr(`LAOT_IRQ_MASK_ADDR, 16'h0000);
		end
		end_test("access_policy");
		stop_test();
	end

endmodule : laot_regs_tb_top
